// ### verilog/ppc_params.svh
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH
// ==========================================
// Register byte addresses
`define PPC_ADDR_RSVD7      12'h000
`define PPC_ADDR_WTCTL      12'h004
`define PPC_ADDR_STATUS     12'h008
`define PPC_ADDR_CODEC      12'h00C
// ==========================================
// Control field positions
`define PPC_BIT_FORCE_RST   0
`define PPC_BIT_CLK_DIS     1
`define PPC_BIT_SP_SWITCH   2
`define PPC_BIT_SYN_EN      3
// ==========================================
// Reset values
`define PPC_WTCTL_RESET     4'h0
`define PPC_ZERO_WORD       32'h0000_0000
`endif

// ### verilog/ppc_pkg.sv
package ppc_pkg;
  // Control bits of the wavetable pin control register
  typedef struct packed {
    logic syn_en;
    logic sp_switch;
    logic clk_dis;
    logic force_rst;
  } ppc_ctrl_t;
  // Pin steering result
  typedef struct packed {
    logic serial_on_pd41;
    logic sout_on_pd3;
    logic synth_on_pd75;
    logic sd_block;
    logic vol_remap;
  } ppc_route_t;
endpackage

// ### verilog/ppc_route.sv
`timescale 1ns/10ps
module ppc_route (
  // Control
  input  wire ppc_pkg::ppc_ctrl_t  i_ctrl,
  input  wire logic                i_serial_port_enable,
  // Steering
  output ppc_pkg::ppc_route_t      o_route
);
  import ppc_pkg::*;
  always_comb begin
    o_route.serial_on_pd41 = i_ctrl.sp_switch & i_serial_port_enable;
    o_route.sout_on_pd3    = i_ctrl.sp_switch;
    o_route.synth_on_pd75  = i_ctrl.syn_en;
    o_route.sd_block       = i_ctrl.sp_switch | i_ctrl.syn_en;
    o_route.vol_remap      = i_ctrl.syn_en;
  end
endmodule

// ### verilog/ppc_top.sv
`timescale 1ns/10ps
`include "ppc_params.svh"
module ppc_top (
  // Clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [3:0]  I_PSTRB,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // EEPROM configuration load
  input  wire logic        I_CFG_LOAD,
  input  wire logic        I_CFG_SP_SWITCH,
  input  wire logic        I_CFG_SYN_EN,
  // Synthesizer clock source
  input  wire logic        I_SYNTH_CLK,
  // Pin controls
  output logic             O_PERIPH_RESET_PIN_N,
  output logic             O_SYNTH_MCLK,
  output logic             O_SERIAL_ON_PD41,
  output logic             O_SERIAL_AUDIO_OUT_ON_PD3,
  output logic             O_SYNTH_ON_PD75,
  output logic             O_SD_BLOCK,
  output logic             O_VOL_REMAP
);
  import ppc_pkg::*;

  // ==========================================
  // Register state
  ppc_ctrl_t   ctrl;
  ppc_ctrl_t   next_ctrl;
  logic        serial_port_enable;
  logic        next_serial_port_enable;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic        pready;
  logic        next_pready;
  logic        pslverr;
  logic        next_pslverr;
  ppc_route_t  route;
  logic        setup;
  logic        wr_ok;
  logic        next_reset_pin_n;
  logic        next_synth_mclk;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `PPC_ADDR_RSVD7) || (a == `PPC_ADDR_WTCTL) ||
               (a == `PPC_ADDR_STATUS) || (a == `PPC_ADDR_CODEC);
  endfunction

  // Zero-wait APB: setup cycle arms pready, access completes one edge later
  assign setup = I_PSEL & ~I_PENABLE;
  assign wr_ok = I_PSEL & I_PENABLE & pready & I_PWRITE & I_PSTRB[0] & addr_hit(I_PADDR);

  always_comb begin
    next_ctrl               = ctrl;
    next_serial_port_enable = serial_port_enable;
    next_pready             = setup;
    next_pslverr            = setup & ~addr_hit(I_PADDR);
    next_prdata             = `PPC_ZERO_WORD;
    if (wr_ok && I_PADDR == `PPC_ADDR_WTCTL) begin
      // Upper bits of the byte are reserved and simply dropped
      next_ctrl.force_rst = I_PWDATA[`PPC_BIT_FORCE_RST];
      next_ctrl.clk_dis   = I_PWDATA[`PPC_BIT_CLK_DIS];
      next_ctrl.sp_switch = I_PWDATA[`PPC_BIT_SP_SWITCH];
      next_ctrl.syn_en    = I_PWDATA[`PPC_BIT_SYN_EN];
    end
    if (wr_ok && I_PADDR == `PPC_ADDR_CODEC) begin
      next_serial_port_enable = I_PWDATA[0];
    end
    // EEPROM load wins over a same-cycle register write for the serial-port switch and synth enable bits, since it runs at bring-up
    if (I_CFG_LOAD) begin
      next_ctrl.sp_switch = I_CFG_SP_SWITCH;
      next_ctrl.syn_en    = I_CFG_SYN_EN;
    end
    if (setup && !I_PWRITE) begin
      case (I_PADDR)
        `PPC_ADDR_WTCTL:  next_prdata[3:0] = ctrl;
        `PPC_ADDR_STATUS: next_prdata[4:0] = route;
        `PPC_ADDR_CODEC:  next_prdata[0]   = serial_port_enable;
        default:          next_prdata      = `PPC_ZERO_WORD;
      endcase
    end else if (!setup) begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrl               <= `PPC_WTCTL_RESET;
      serial_port_enable <= 1'b0;
      prdata             <= `PPC_ZERO_WORD;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
    end else begin
      ctrl               <= next_ctrl;
      serial_port_enable <= next_serial_port_enable;
      prdata             <= next_prdata;
      pready             <= next_pready;
      pslverr            <= next_pslverr;
    end
  end

  assign O_PRDATA  = prdata;
  assign O_PREADY  = pready;
  assign O_PSLVERR = pslverr;

  // ==========================================
  // Pin steering
  ppc_route u_route (
    .i_ctrl               (ctrl),
    .i_serial_port_enable (serial_port_enable),
    .o_route              (route)
  );

  // Clock gate is registered so the output stays a flop; the clock is sampled, not passed through
  always_comb begin
    next_reset_pin_n = ~ctrl.force_rst;
    next_synth_mclk  = I_SYNTH_CLK & ~ctrl.clk_dis;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_PERIPH_RESET_PIN_N      <= 1'b1;
      O_SYNTH_MCLK              <= 1'b0;
      O_SERIAL_ON_PD41          <= 1'b0;
      O_SERIAL_AUDIO_OUT_ON_PD3 <= 1'b0;
      O_SYNTH_ON_PD75           <= 1'b0;
      O_SD_BLOCK                <= 1'b0;
      O_VOL_REMAP               <= 1'b0;
    end else begin
      O_PERIPH_RESET_PIN_N      <= next_reset_pin_n;
      O_SYNTH_MCLK              <= next_synth_mclk;
      O_SERIAL_ON_PD41          <= route.serial_on_pd41;
      O_SERIAL_AUDIO_OUT_ON_PD3 <= route.sout_on_pd3;
      O_SYNTH_ON_PD75           <= route.synth_on_pd75;
      O_SD_BLOCK                <= route.sd_block;
      O_VOL_REMAP               <= route.vol_remap;
    end
  end

  // ==========================================
  // Assertions
  property p_rst_pin;
    @(posedge I_CORE_CLK) disable iff (I_RST) ctrl.force_rst |=> !O_PERIPH_RESET_PIN_N;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin not low");
  property p_mclk;
    @(posedge I_CORE_CLK) disable iff (I_RST) ctrl.clk_dis |=> !O_SYNTH_MCLK;
  endproperty
  a_mclk: assert property (p_mclk) else $error("mclk not gated");
  property p_pd41;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (ctrl.sp_switch && serial_port_enable) |=> O_SERIAL_ON_PD41;
  endproperty
  a_pd41: assert property (p_pd41) else $error("serial not on pins 4..1");
  property p_pd41_off;
    @(posedge I_CORE_CLK) disable iff (I_RST) !serial_port_enable |=> !O_SERIAL_ON_PD41;
  endproperty
  a_pd41_off: assert property (p_pd41_off) else $error("serial on pins without enable");
  property p_sd_sps;
    @(posedge I_CORE_CLK) disable iff (I_RST) ctrl.sp_switch |=> O_SD_BLOCK;
  endproperty
  a_sd_sps: assert property (p_sd_sps) else $error("data bus not blocked");
  property p_cfg;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      I_CFG_LOAD |=> (ctrl.sp_switch == $past(I_CFG_SP_SWITCH)) && (ctrl.syn_en == $past(I_CFG_SYN_EN));
  endproperty
  a_cfg: assert property (p_cfg) else $error("config load lost");
  property p_pd75;
    @(posedge I_CORE_CLK) disable iff (I_RST) ctrl.syn_en |=> O_SYNTH_ON_PD75 && O_VOL_REMAP && O_SD_BLOCK;
  endproperty
  a_pd75: assert property (p_pd75) else $error("synth port not steered");
  property p_rsv;
    @(posedge I_CORE_CLK) disable iff (I_RST) O_PREADY |-> O_PRDATA[31:5] == 27'h000_0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_pd3;
    @(posedge I_CORE_CLK) disable iff (I_RST) ##1 O_SERIAL_AUDIO_OUT_ON_PD3 == $past(ctrl.sp_switch);
  endproperty
  a_pd3: assert property (p_pd3) else $error("serial out pin wrong");
  property p_rst;
    @(posedge I_CORE_CLK) $fell(I_RST) |-> ctrl == 4'h0 && O_PERIPH_RESET_PIN_N;
  endproperty
  a_rst: assert property (p_rst) else $error("control not clear after reset");
  property p_ready;
    @(posedge I_CORE_CLK) disable iff (I_RST) (I_PSEL && !I_PENABLE) |=> O_PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_rst_pin_off;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      !ctrl.force_rst |=> O_PERIPH_RESET_PIN_N;
  endproperty
  a_rst_pin_off: assert property (p_rst_pin_off) else $error("reset pin held low");
  // Sampled reset keeps out the release edge, where the pin still shows its reset level
  property p_mclk_pass;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (!I_RST && !ctrl.clk_dis) |=> O_SYNTH_MCLK == $past(I_SYNTH_CLK);
  endproperty
  a_mclk_pass: assert property (p_mclk_pass) else $error("mclk not passed");
  property p_pd41_sw_off;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      !ctrl.sp_switch |=> !O_SERIAL_ON_PD41;
  endproperty
  a_pd41_sw_off: assert property (p_pd41_sw_off) else $error("serial on pins without switch");
  property p_sd_syn;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      ctrl.syn_en |=> O_SD_BLOCK;
  endproperty
  a_sd_syn: assert property (p_sd_syn) else $error("data bus not blocked by synth port");
  property p_sd_off;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (!ctrl.sp_switch && !ctrl.syn_en) |=> !O_SD_BLOCK;
  endproperty
  a_sd_off: assert property (p_sd_off) else $error("data bus blocked without cause");
  property p_vol_off;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      !ctrl.syn_en |=> !O_VOL_REMAP && !O_SYNTH_ON_PD75;
  endproperty
  a_vol_off: assert property (p_vol_off) else $error("volume remapped without synth port");
  property p_spe_wr;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (wr_ok && I_PADDR == `PPC_ADDR_CODEC) |=> serial_port_enable == $past(I_PWDATA[0]);
  endproperty
  a_spe_wr: assert property (p_spe_wr) else $error("serial port enable not written");
  property p_cfg_wins;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (I_CFG_LOAD && wr_ok && I_PADDR == `PPC_ADDR_WTCTL)
        |=> ctrl.force_rst == $past(I_PWDATA[`PPC_BIT_FORCE_RST]) && ctrl.sp_switch == $past(I_CFG_SP_SWITCH);
  endproperty
  a_cfg_wins: assert property (p_cfg_wins) else $error("config load and write mixed wrongly");

  // ==========================================
  // Bus assertions
  property p_wr_land;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (wr_ok && I_PADDR == `PPC_ADDR_WTCTL && !I_CFG_LOAD) |=> ctrl == $past(I_PWDATA[3:0]);
  endproperty
  a_wr_land: assert property (p_wr_land) else $error("control write lost");
  property p_no_wr;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (I_PSEL && I_PENABLE && I_PWRITE && !I_CFG_LOAD && (!I_PSTRB[0] || !addr_hit(I_PADDR)))
        |=> $stable(ctrl) && $stable(serial_port_enable);
  endproperty
  a_no_wr: assert property (p_no_wr) else $error("refused write changed state");
  property p_err;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (I_PSEL && !I_PENABLE) |=> O_PSLVERR == !addr_hit($past(I_PADDR));
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  property p_ready_pulse;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      O_PREADY |=> !O_PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_ready_only;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      O_PREADY |-> $past(I_PSEL && !I_PENABLE);
  endproperty
  a_ready_only: assert property (p_ready_only) else $error("ready without setup");
  property p_rd_ctrl;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == `PPC_ADDR_WTCTL) |=> O_PRDATA == {28'h000_0000, $past(ctrl)};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");
  property p_rd_status;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == `PPC_ADDR_STATUS) |=> O_PRDATA == {27'h000_0000, $past(route)};
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read wrong");
  property p_rd_codec;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == `PPC_ADDR_CODEC)
        |=> O_PRDATA == {31'h0000_0000, $past(serial_port_enable)};
  endproperty
  a_rd_codec: assert property (p_rd_codec) else $error("codec read wrong");
  property p_rsv7;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == `PPC_ADDR_RSVD7) |=> O_PRDATA == `PPC_ZERO_WORD;
  endproperty
  a_rsv7: assert property (p_rsv7) else $error("reserved register not zero");
  property p_rd_hold;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (!I_PSEL || I_PENABLE) |=> $stable(O_PRDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  c_wr: cover property (@(posedge I_CORE_CLK) wr_ok && I_PADDR == `PPC_ADDR_WTCTL);
  c_cfg: cover property (@(posedge I_CORE_CLK) I_CFG_LOAD && I_CFG_SYN_EN);
  c_err: cover property (@(posedge I_CORE_CLK) O_PSLVERR);
  c_rst_pin: cover property (@(posedge I_CORE_CLK) !O_PERIPH_RESET_PIN_N && O_SYNTH_ON_PD75);
  c_pd41: cover property (@(posedge I_CORE_CLK) O_SERIAL_ON_PD41 && !O_SYNTH_MCLK);
endmodule

// ### verification/ppc_periph_model.sv
`timescale 1ns/10ps
// ====
// Synthesizer side model
module ppc_periph_model (
  // Clock and pins
  input  wire logic       i_clk,
  input  wire logic       i_reset_pin_n,
  input  wire logic       i_mclk,
  // Clock source and activity count
  output logic            o_clk_src,
  output logic      [7:0] o_rises
);
  logic last;
  initial begin
    o_clk_src = 1'b0;
    o_rises   = 8'h00;
    last      = 1'b0;
  end
  // A peripheral held in reset ignores its clock
  always @(posedge i_clk) begin
    o_clk_src <= ~o_clk_src;
    last      <= i_mclk;
    if (i_mclk && !last && i_reset_pin_n) begin
      o_rises <= o_rises + 8'h01;
    end
  end
endmodule

// ### verification/tb_top.sv
`timescale 1ns/10ps
`include "ppc_params.svh"
module tb_top;
  import ppc_pkg::*;
  logic        clk, rst, psel, pen, pwr, ld, ld_sp, ld_syn, port_en, src;
  logic [3:0]  pstrb, strb;
  logic        pready, pslverr, rpin_n, mclk, on41, on3, on75, sdb, vrm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr;
  logic [7:0]  rises, r0;
  logic [33:0] expq[$];
  logic [33:0] e;
  int          miscompares, n_tests;
  ppc_top dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_CFG_LOAD(ld), .I_CFG_SP_SWITCH(ld_sp), .I_CFG_SYN_EN(ld_syn),
    .I_SYNTH_CLK(src), .O_PERIPH_RESET_PIN_N(rpin_n), .O_SYNTH_MCLK(mclk), .O_SERIAL_ON_PD41(on41),
    .O_SERIAL_AUDIO_OUT_ON_PD3(on3), .O_SYNTH_ON_PD75(on75), .O_SD_BLOCK(sdb), .O_VOL_REMAP(vrm));
  ppc_periph_model periph_u (.i_clk(clk), .i_reset_pin_n(rpin_n), .i_mclk(mclk), .o_clk_src(src),
    .o_rises(rises));
  // ====
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= strb;
    @(posedge clk);
    pen <= 1'b1;
    // Wait ends once pready is seen high; only the watchdog ends it if pready never comes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
    expq.push_back({!err, err, d});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ====
  // Read monitor
  always @(posedge clk) begin
    if (psel && pen && !pwr && pready === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      n_tests++;
      if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
        miscompares++;
        $display("[ERR] %0t read %h err %b exp %h", $time, prdata, pslverr, e[31:0]);
      end
    end
  end
  // ====
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
    ld = 1'b0; ld_sp = 1'b0; ld_syn = 1'b0; lfsr = 32'hdbf3_dca5;
    pstrb = 4'hF;
    strb  = 4'hF;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({rpin_n, on41, on3, on75, sdb, vrm}, 32'h0000_0020);
    rd(`PPC_ADDR_WTCTL, 32'h0000_0000, 1'b0);
    rd(`PPC_ADDR_RSVD7, 32'h0000_0000, 1'b0);
    rd(12'h010, 32'h0000_0000, 1'b1);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      port_en = lfsr[0];
      apb(1'b1, `PPC_ADDR_CODEC, {31'h0000_0000, port_en});
      apb(1'b1, `PPC_ADDR_WTCTL, i);
      repeat (2) @(posedge clk);
      #1;
      r0 = rises;
      chk(rpin_n, !i[0]);
      chk(on41, i[2] & port_en);
      chk(on3, i[2]);
      chk(on75, i[3]);
      chk(sdb, i[2] | i[3]);
      chk(vrm, i[3]);
      repeat (6) @(posedge clk);
      #1;
      chk(rises !== r0, !i[1] && !i[0]);
      if (i[1]) chk(mclk, 1'b0);
      rd(`PPC_ADDR_WTCTL, i, 1'b0);
    end
    $display("control test done");
    apb(1'b1, `PPC_ADDR_WTCTL, 32'h0000_0000);
    @(posedge clk);
    ld <= 1'b1; ld_sp <= 1'b1; ld_syn <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    rd(`PPC_ADDR_WTCTL, 32'h0000_000C, 1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk(sdb & on75, 1'b1);
    $display("load test done");
    // Lane 0 strobe low and an unmapped address must both leave control untouched
    strb = 4'h0;
    apb(1'b1, `PPC_ADDR_WTCTL, 32'h0000_0003);
    strb = 4'hF;
    apb(1'b1, 12'h010, 32'h0000_0003);
    rd(`PPC_ADDR_WTCTL, 32'h0000_000C, 1'b0);
    $display("refused write test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`PPC_ADDR_WTCTL, 32'h0000_0000, 1'b0);
    #1;
    chk({rpin_n, on41, on3, on75, sdb, vrm}, 32'h0000_0020);
    $display("second reset test done");
    give_verdict();
  end
endmodule
